// file: include/bcbd_map.svh
// bcbd_map.svh: opcode patterns, field positions and address bases
// assumes 24-bit instruction words with the opcode class in bits 23..16
`ifndef BCBD_MAP_SVH
`define BCBD_MAP_SVH
`define BCBD_UB_TSTCLR    8'h0A
`define BCBD_UB_TSTCLR_LO 8'h01
`define BCBD_UB_BRZERO    8'h0C
`define BCBD_UB_BRZERO_LO 8'h04
`define BCBD_UB_ALW       8'h0D
`define BCBD_UB_ALW_S     8'h05
`define BCBD_ALW_LONG     24'h0D10C0
`define BCBD_ALW_REG_MID  5'h03
`define BCBD_ALW_TAIL     8'hC0
`define BCBD_ALW_S_MID    6'h03
`define BCBD_IO_HI_BASE  24'hFFFFC0
`define BCBD_IO_LO_BASE  24'hFFFF80
`define BCBD_EA_EXT_MODE 3'h6
`define BCBD_BIT_LIMIT   5'h18
`define BCBD_PC_STEP1    24'h000001
`define BCBD_PC_STEP2    24'h000002
`endif

// file: include/bcbd_pkg.sv
// bcbd_pkg: types shared by the bit-clear and branch decoder
// takes nothing from bcbd_map.svh; its enum encodings are given here
package bcbd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_AREG = 2'b01, ST_RD = 2'b10, ST_WR = 2'b11
  } bcbd_state_e;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_TSTCLR = 3'b001, OP_BRZERO = 3'b010,
    OP_ALW_L = 3'b011, OP_ALW_S = 3'b100, OP_ALW_R = 3'b101
  } bcbd_op_e;
  typedef enum logic [2:0] {
    K_EA = 3'b000, K_ABS = 3'b001, K_IOHI = 3'b010,
    K_IOLO = 3'b011, K_REG = 3'b100
  } bcbd_kind_e;
  typedef struct packed {
    bcbd_op_e   op;
    bcbd_kind_e kind;
    logic [4:0] bitn;
    logic       space;
    logic [5:0] field;
    logic       ext;
  } bcbd_dec_s;
endpackage

// file: core/bcbd_decoder.sv
// bcbd_decoder: decode and execute of bit test-and-clear, branch always
// and branch-if-bit-clear; assumes the fetch path offers the opcode word
// and its following word together, and an operand unit that acks accesses
//
// Contract
// - decode effective-address test-and-clear; optional extension word.
// - decode test-and-clear on absolute short address 0 to 63.
// - decode test-and-clear on upper I/O window and on-chip register.
// - decode test-and-clear on lower I/O window, space bit in bit 6.
// - bit goes to carry, operand written back cleared, bus held locked.
// - branch always loads PC plus signed displacement.
// - long branch uses fixed opcode and 24-bit extension displacement.
// - short branch sign-extends a 9-bit split displacement.
// - register branch adds one of eight address registers to PC.
// - branch always never touches condition flags.
// - branch-if-clear jumps to PC plus displacement when bit is zero.
// - branch-if-clear falls through when the tested bit is one.
// - post-modify address update happens whether or not branching.
// - branch-if-clear displacement comes from the extension word.
// - reading system stack high as branch-if-clear source decrements stack pointer.
// - branch-if-clear bit position is immediate, 0 to 23 only.
// - branch-if-clear takes memory, absolute, both I/O and register.
`include "bcbd_map.svh"
`timescale 1ns/1ns
`default_nettype none
module bcbd_decoder import bcbd_pkg::*; #(
  parameter int          WORD_W   = 24,
  parameter logic [5:0]  STK_HIGH_CODE = 6'h3C
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // fetch side
  input  wire logic              instr_valid,
  input  wire logic [WORD_W-1:0] instr_word,
  input  wire logic [WORD_W-1:0] instr_ext,
  input  wire logic [WORD_W-1:0] instr_pc,
  output logic                   instr_ready,
  // address register read
  output logic [2:0]             areg_sel,
  input  wire logic [WORD_W-1:0] areg_data,
  // operand access
  output logic                   opr_req,
  output logic                   opr_we,
  output logic                   opr_lock,
  output bcbd_kind_e             opr_kind,
  output logic                   opr_space,
  output logic [5:0]             opr_field,
  output logic [WORD_W-1:0]      opr_addr,
  output logic [WORD_W-1:0]      opr_wdata,
  input  wire logic              opr_ack,
  input  wire logic [WORD_W-1:0] opr_rdata,
  // program control results
  output logic                   done,
  output logic                   illegal,
  output logic                   pc_load,
  output logic [WORD_W-1:0]      pc_value,
  output logic                   carry_we,
  output logic                   carry_val,
  output logic                   ea_update,
  output logic                   sp_dec
);
  if (WORD_W != 24) begin : g_chk
    $error("bcbd_decoder serves 24-bit words only");
  end

  function automatic logic [23:0] pc_add(input logic [23:0] a,
                                         input logic [23:0] b);
    pc_add = a + b;
  endfunction

  function automatic bcbd_dec_s decode(input logic [23:0] w);
    bcbd_dec_s d;
    d       = '0;
    d.op    = OP_NONE;
    d.kind  = K_EA;
    d.bitn  = w[4:0];
    d.space = w[6];
    d.field = w[13:8];
    case (w[23:16])
      `BCBD_UB_TSTCLR: begin
        case (w[15:14])
          2'b00: if (!w[7] && !w[5]) d.op = OP_TSTCLR;
          2'b01: if (!w[7] && !w[5]) d.op = OP_TSTCLR;
          2'b10: if (!w[7] && !w[5]) d.op = OP_TSTCLR;
          default: if (w[7:6] == 2'b01 && !w[5]) d.op = OP_TSTCLR;
        endcase
        d.kind = (w[15:14] == 2'b00) ? K_ABS :
                 (w[15:14] == 2'b01) ? K_EA  :
                 (w[15:14] == 2'b10) ? K_IOHI : K_REG;
        d.ext  = (w[15:14] == 2'b01) &&
                 (w[13:11] == `BCBD_EA_EXT_MODE);
      end
      `BCBD_UB_TSTCLR_LO: begin
        if (w[15:14] == 2'b00 && !w[7] && !w[5]) begin
          d.op = OP_TSTCLR;
        end
        d.kind = K_IOLO;
      end
      `BCBD_UB_BRZERO: begin
        if (w[15] && !w[5]) begin
          if (!w[14]) begin
            d.op   = OP_BRZERO;
            d.kind = w[7] ? K_ABS : K_EA;
          end else if (!w[7] || !w[6]) begin
            d.op   = OP_BRZERO;
            d.kind = w[7] ? K_REG : K_IOHI;
          end
        end
        d.ext = 1'b1;
      end
      `BCBD_UB_BRZERO_LO: begin
        if (w[15:14] == 2'b10 && !w[7] && !w[5]) d.op = OP_BRZERO;
        d.kind = K_IOLO;
        d.ext  = 1'b1;
      end
      `BCBD_UB_ALW: begin
        if (w == `BCBD_ALW_LONG) begin
          d.op  = OP_ALW_L;
          d.ext = 1'b1;
        end else if (w[15:11] == `BCBD_ALW_REG_MID &&
                     w[7:0] == `BCBD_ALW_TAIL) begin
          d.op = OP_ALW_R;
        end
      end
      `BCBD_UB_ALW_S: begin
        if (w[15:10] == `BCBD_ALW_S_MID && !w[5]) begin
          d.op = OP_ALW_S;
        end
      end
      default: d.op = OP_NONE;
    endcase
    if ((d.op == OP_TSTCLR || d.op == OP_BRZERO) &&
        d.bitn >= `BCBD_BIT_LIMIT) begin
      d.op = OP_NONE;
    end
    return d;
  endfunction

  bcbd_dec_s   dec;
  bcbd_state_e state_q;
  bcbd_op_e    op_q;
  logic [4:0]  bit_q;
  logic [23:0] pc_q;
  logic [23:0] disp_q;
  logic [23:0] len_q;
  logic [23:0] short_disp;
  logic [23:0] mask;
  logic        take_new;
  logic        tested;
  logic        fin;

  assign dec        = decode(instr_word);
  assign take_new   = (state_q == ST_IDLE) && instr_valid;
  assign short_disp = {{15{instr_word[9]}}, instr_word[9:6],
                       instr_word[4:0]};
  assign mask       = 24'h000001 << bit_q;
  assign tested     = opr_rdata[bit_q];
  assign fin = (take_new && (dec.op == OP_NONE || dec.op == OP_ALW_L ||
                             dec.op == OP_ALW_S)) ||
               (state_q == ST_AREG) ||
               (state_q == ST_RD && opr_ack && op_q == OP_BRZERO) ||
               (state_q == ST_WR && opr_ack);

  // sequencing and operand access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      op_q        <= OP_NONE;
      bit_q       <= 5'h00;
      pc_q        <= 24'h000000;
      disp_q      <= 24'h000000;
      len_q       <= 24'h000000;
      instr_ready <= 1'b0;
      areg_sel    <= 3'h0;
      opr_req     <= 1'b0;
      opr_we      <= 1'b0;
      opr_lock    <= 1'b0;
      opr_kind    <= K_EA;
      opr_space   <= 1'b0;
      opr_field   <= 6'h00;
      opr_addr    <= 24'h000000;
      opr_wdata   <= 24'h000000;
    end else begin
      instr_ready <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          instr_ready <= !instr_valid;
          if (instr_valid) begin
            op_q      <= dec.op;
            bit_q     <= dec.bitn;
            pc_q      <= instr_pc;
            disp_q    <= instr_ext;
            len_q     <= dec.ext ? `BCBD_PC_STEP2 : `BCBD_PC_STEP1;
            opr_kind  <= dec.kind;
            opr_space <= dec.space;
            opr_field <= dec.field;
            areg_sel  <= instr_word[10:8];
            case (dec.kind)
              K_ABS:   opr_addr <= {18'h0, dec.field};
              K_IOHI:  opr_addr <= `BCBD_IO_HI_BASE | {18'h0, dec.field};
              K_IOLO:  opr_addr <= `BCBD_IO_LO_BASE | {18'h0, dec.field};
              K_EA:    opr_addr <= (dec.op == OP_TSTCLR && dec.ext) ?
                                   instr_ext : 24'h000000;
              default: opr_addr <= 24'h000000;
            endcase
            if (dec.op == OP_ALW_R) begin
              state_q <= ST_AREG;
            end else if (dec.op == OP_TSTCLR || dec.op == OP_BRZERO) begin
              state_q  <= ST_RD;
              opr_req  <= 1'b1;
              opr_lock <= (dec.op == OP_TSTCLR);
            end
          end
        end
        ST_AREG: begin
          state_q     <= ST_IDLE;
          instr_ready <= 1'b1;
        end
        ST_RD: begin
          if (opr_ack) begin
            if (op_q == OP_TSTCLR) begin
              state_q   <= ST_WR;
              opr_we    <= 1'b1;
              opr_wdata <= opr_rdata & ~mask;
            end else begin
              state_q     <= ST_IDLE;
              opr_req     <= 1'b0;
              opr_lock    <= 1'b0;
              instr_ready <= 1'b1;
            end
          end
        end
        ST_WR: begin
          if (opr_ack) begin
            state_q     <= ST_IDLE;
            opr_req     <= 1'b0;
            opr_we      <= 1'b0;
            opr_lock    <= 1'b0;
            instr_ready <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // results toward program control
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done      <= 1'b0;
      illegal   <= 1'b0;
      pc_load   <= 1'b0;
      pc_value  <= 24'h000000;
      carry_we  <= 1'b0;
      carry_val <= 1'b0;
      ea_update <= 1'b0;
      sp_dec    <= 1'b0;
    end else begin
      done      <= fin;
      pc_load   <= fin;
      illegal   <= fin && take_new && dec.op == OP_NONE;
      carry_we  <= 1'b0;
      ea_update <= 1'b0;
      sp_dec    <= 1'b0;
      if (take_new) begin
        case (dec.op)
          OP_ALW_L: pc_value <= pc_add(instr_pc, instr_ext);
          OP_ALW_S: pc_value <= pc_add(instr_pc, short_disp);
          default:  pc_value <= pc_add(instr_pc, `BCBD_PC_STEP1);
        endcase
      end else if (state_q == ST_AREG) begin
        pc_value <= pc_add(pc_q, areg_data);
      end else if (state_q == ST_RD && opr_ack) begin
        if (op_q == OP_BRZERO) begin
          pc_value  <= tested ? pc_add(pc_q, len_q)
                              : pc_add(pc_q, disp_q);
          ea_update <= (opr_kind == K_EA);
          sp_dec    <= (opr_kind == K_REG) &&
                       (opr_field == STK_HIGH_CODE);
        end else begin
          carry_val <= tested;
          pc_value  <= pc_add(pc_q, len_q);
        end
      end else if (state_q == ST_WR && opr_ack) begin
        carry_we  <= 1'b1;
        ea_update <= (opr_kind == K_EA);
      end
    end
  end

  wr_lock_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    opr_we |-> opr_lock && opr_req)
    else $error("write not locked");
  clr_data_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_RD && opr_ack && op_q == OP_TSTCLR |=>
      opr_we && opr_wdata == ($past(opr_rdata) & ~$past(mask))
      && opr_wdata[$past(bit_q)] == 1'b0)
    else $error("bad clear data");
  alw_flags_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    carry_we |-> $past(op_q) == OP_TSTCLR)
    else $error("flags hit");
  alw_long_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take_new && instr_word == `BCBD_ALW_LONG |=> pc_load && !illegal &&
      pc_value == $past(instr_pc) + $past(instr_ext))
    else $error("long branch target wrong");
  alw_short_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take_new && dec.op == OP_ALW_S |=>
      pc_value == $past(instr_pc) + $past(short_disp))
    else $error("short branch target wrong");
  alw_reg_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take_new && dec.op == OP_ALW_R |=> ##1 pc_load &&
      pc_value == $past(pc_q) + $past(areg_data))
    else $error("register branch wrong");
  brzero_pc_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_RD && opr_ack && op_q == OP_BRZERO |=> pc_load &&
      pc_value == ($past(tested) ? $past(pc_q) + $past(len_q)
                                 : $past(pc_q) + $past(disp_q)))
    else $error("bit branch target wrong");
  ea_upd_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_RD && opr_ack && op_q == OP_BRZERO && opr_kind == K_EA
      |=> ea_update)
    else $error("ea update missed");
  stk_pop_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    sp_dec |-> $past(opr_field) == STK_HIGH_CODE && $past(opr_kind) == K_REG)
    else $error("stray stack decrement");
  bit_range_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take_new && instr_word[23:16] == `BCBD_UB_BRZERO &&
      instr_word[4:0] >= `BCBD_BIT_LIMIT |=> illegal)
    else $error("bit above 23 accepted");
endmodule // bcbd_decoder
`default_nettype wire

// file: sim/tb.sv
// tb: self-checking bench for the bit-clear and branch decoder
// assumes bcbd_pkg is compiled first; the bench acts as fetch path,
// address register file and operand unit, driving at the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bcbd_pkg::*;
  logic        clk_sys, rst_n, instr_valid, opr_ack, instr_ready;
  logic [23:0] instr_word, instr_ext, instr_pc, areg_data, opr_rdata;
  logic        opr_req, opr_we, opr_lock, opr_space, done, illegal;
  logic        pc_load, carry_we, carry_val, ea_update, sp_dec;
  logic [2:0]  areg_sel;
  bcbd_kind_e  opr_kind;
  logic [5:0]  opr_field;
  logic [23:0] opr_addr, opr_wdata, pc_value;
  int          n_errors, checks_done, cycles;

  bcbd_decoder u_bcbd_decoder (
    .clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ext(instr_ext), .instr_pc(instr_pc),
    .instr_ready(instr_ready), .areg_sel(areg_sel), .areg_data(areg_data),
    .opr_req(opr_req), .opr_we(opr_we), .opr_lock(opr_lock),
    .opr_kind(opr_kind), .opr_space(opr_space), .opr_field(opr_field),
    .opr_addr(opr_addr), .opr_wdata(opr_wdata), .opr_ack(opr_ack),
    .opr_rdata(opr_rdata), .done(done), .illegal(illegal),
    .pc_load(pc_load), .pc_value(pc_value), .carry_we(carry_we),
    .carry_val(carry_val), .ea_update(ea_update), .sp_dec(sp_dec));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // hang guard: the whole sequence needs under a hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_flag(input string what, input logic exp, got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [23:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic issue(input logic [23:0] w, x, pc);
    @(negedge clk_sys);
    instr_valid = 1'b1;
    instr_word = w;
    instr_ext = x;
    instr_pc = pc;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    instr_ext = ~x;
  endtask

  // done stands one cycle, so it is looked at before waiting further
  task automatic wait_done(output int n);
    n = 1;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  task automatic wait_req(input logic we);
    int k;
    k = 0;
    while (!(opr_req === 1'b1 && opr_we === we) && k < 40) begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  // released read data shows the inverse so stale values are not trusted
  task automatic ack(input logic [23:0] d, input int stall);
    repeat (stall) @(negedge clk_sys);
    opr_ack = 1'b1;
    opr_rdata = d;
    @(negedge clk_sys);
    opr_ack = 1'b0;
    opr_rdata = ~d;
  endtask

  task automatic run_alw(input logic [23:0] w, x, pc, exp, input int lat);
    int c;
    issue(w, x, pc);
    wait_done(c);
    chk_word("alw latency", lat, c);
    chk_flag("alw pc_load", 1'b1, pc_load);
    chk_word("alw pc", exp, pc_value);
    chk_flag("alw carry_we", 1'b0, carry_we);
    chk_flag("alw illegal", 1'b0, illegal);
  endtask

  task automatic t_alw();
    run_alw(24'h0D10C0, 24'h800000, 24'h000010, 24'h800010, 1);
    run_alw({8'h05, 6'h03, 4'h8, 1'b0, 5'h01}, 24'h0, 24'h000300,
            24'h000201, 1);
    run_alw({8'h05, 6'h03, 4'h7, 1'b0, 5'h1F}, 24'h0, 24'h000300,
            24'h0003FF, 1);
    areg_data = 24'hFFFFFE;
    run_alw({8'h0D, 5'h03, 3'h5, 8'hC0}, 24'h0, 24'h000400,
            24'h0003FE, 2);
    chk_word("areg_sel", 24'h000005, {21'h0, areg_sel});
    $display("test branch always finished");
  endtask

  task automatic run_tclr(input logic [23:0] w, x, a, d, step,
                          input bcbd_kind_e kd, input logic [4:0] n,
                          input int stall);
    int c;
    issue(w, x, 24'h000100);
    wait_req(1'b0);
    chk_word("kind", {21'h0, kd}, {21'h0, opr_kind});
    chk_word("addr", a, opr_addr);
    chk_flag("space", w[6], opr_space);
    chk_word("field", {18'h0, w[13:8]}, opr_field);
    chk_flag("lock rd", 1'b1, opr_lock);
    ack(d, stall);
    wait_req(1'b1);
    chk_word("wdata", d & ~(24'h000001 << n), opr_wdata);
    chk_flag("lock wr", 1'b1, opr_lock);
    ack(24'h0, stall);
    wait_done(c);
    chk_word("tclr latency", 24'h000001, c);
    chk_flag("carry_we", 1'b1, carry_we);
    chk_flag("carry", d[n], carry_val);
    chk_flag("tclr ea", kd == K_EA, ea_update);
    chk_word("tclr pc", 24'h000100 + step, pc_value);
  endtask

  task automatic t_tclr();
    run_tclr({8'h0A, 2'b01, 6'h30, 3'b010, 5'd23}, 24'h001234, 24'h001234,
             24'h800001, 24'h000002, K_EA, 5'd23, 0);
    run_tclr({8'h0A, 2'b00, 6'h3F, 3'b000, 5'd0}, 24'h0, 24'h00003F,
             24'h0000FE, 24'h000001, K_ABS, 5'd0, 2);
    run_tclr({8'h0A, 2'b10, 6'h05, 3'b000, 5'd7}, 24'h0, 24'hFFFFC5,
             24'hFFFFFF, 24'h000001, K_IOHI, 5'd7, 1);
    run_tclr({8'h01, 2'b00, 6'h3F, 3'b010, 5'd12}, 24'h0, 24'hFFFFBF,
             24'h001000, 24'h000001, K_IOLO, 5'd12, 3);
    run_tclr({8'h0A, 2'b11, 6'h0E, 3'b010, 5'd5}, 24'h0, 24'h0,
             24'h000020, 24'h000001, K_REG, 5'd5, 0);
    $display("test bit clear finished");
  endtask

  task automatic run_bz(input logic [23:0] w, a, d,
                           input bcbd_kind_e kd, input logic tk, eau, spd);
    int c;
    issue(w, 24'hFFFFF0, 24'h000200);
    wait_req(1'b0);
    chk_word("br kind", {21'h0, kd}, {21'h0, opr_kind});
    chk_word("br addr", a, opr_addr);
    chk_flag("br space", w[6], opr_space);
    chk_flag("br lock", 1'b0, opr_lock);
    ack(d, 1);
    wait_done(c);
    chk_word("br latency", 24'h000001, c);
    chk_flag("br write", 1'b0, opr_we);
    chk_word("br pc", tk ? 24'h0001F0 : 24'h000202,
             pc_value);
    chk_flag("br ea", eau, ea_update);
    chk_flag("br sp_dec", spd, sp_dec);
  endtask

  task automatic t_bz();
    run_bz({8'h0C, 2'b10, 6'h1A, 3'b010, 5'd9}, 24'h0, 24'hFFFDFF,
           K_EA, 1'b1, 1'b1, 1'b0);
    run_bz({8'h0C, 2'b10, 6'h1A, 3'b010, 5'd9}, 24'h0, 24'h000200,
           K_EA, 1'b0, 1'b1, 1'b0);
    run_bz({8'h0C, 2'b10, 6'h2A, 3'b100, 5'd23}, 24'h00002A,
           24'h800000, K_ABS, 1'b0, 1'b0, 1'b0);
    run_bz({8'h0C, 2'b11, 6'h01, 3'b010, 5'd0}, 24'hFFFFC1,
           24'hFFFFFE, K_IOHI, 1'b1, 1'b0, 1'b0);
    run_bz({8'h04, 2'b10, 6'h3F, 3'b000, 5'd1}, 24'hFFFFBF,
           24'h000002, K_IOLO, 1'b0, 1'b0, 1'b0);
    run_bz({8'h0C, 2'b11, 6'h3C, 3'b100, 5'd3}, 24'h0, 24'h0,
           K_REG, 1'b1, 1'b0, 1'b1);
    $display("test branch if clear finished");
  endtask

  task automatic t_illegal();
    int c;
    issue({8'h0A, 2'b00, 6'h01, 3'b000, 5'd24}, 24'h0, 24'h000500);
    wait_done(c);
    chk_flag("bit 24 illegal", 1'b1, illegal);
    chk_flag("bit 24 no access", 1'b0, opr_req);
    chk_word("bit 24 pc", 24'h000501, pc_value);
    issue({8'h0C, 2'b10, 6'h01, 3'b100, 5'd31}, 24'h0, 24'h000600);
    wait_done(c);
    chk_flag("bit 31 illegal", 1'b1, illegal);
    chk_word("bit 31 pc", 24'h000601, pc_value);
    $display("test illegal finished");
  endtask

  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 24'h0;
    instr_ext = 24'h0;
    instr_pc = 24'h0;
    areg_data = 24'h0;
    opr_ack = 1'b0;
    opr_rdata = 24'h0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    chk_flag("reset done", 1'b0, done);
    chk_flag("reset req", 1'b0, opr_req);
    @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk_flag("idle ready", 1'b1, instr_ready);
    t_alw();
    t_tclr();
    t_bz();
    t_illegal();
    results();
  end
endmodule // tb
`default_nettype wire
